/* File: design/bcl_loader.sv */
`timescale 1ns/100ps
// Function
// - Page 0 unique ID copied, never writable
// - Page 1 factory data copied, never writable
// - Pages 2,3 loaded from EEPROM or OTP
// - Page 4 validity word loaded from EEPROM
// - OTP pages map onto window pages 0-3
// - EEPROM pages map onto window pages 2-4
// - EEPROM bytes big-endian into window words
// - Host reaches window only, never memories
// - OTP write of pages 2,3 only programming
// - Serial clock high at start selects development
// - Zero customer identifier keeps device off
// - EEPROM valid only when word equals A596h
// - Reload bit chooses refetch or current contents
// - Pages 0,1 always reloaded from OTP
// - Checks run even when reload suppressed
// - Reload bit change needs unlock key
// - I2C master reads EEPROM with A1h
// - EEPROM is never written
// - Active-high power request from EEPROM needs OTP polarity
// - Programming state entered only from OFF

////////////////////////////////////////////////////////////////////////////
// Serial EEPROM reader; runs on the link clock.
module bcl_link #(
	// Link cycles per quarter of a serial bit.
	parameter int QUARTER_LEN = bcl_pkg::QUARTER_CYC
) (
	// Link clock and reset.
	input wire logic i2c_clk,
	input wire logic rst,
	// Crossing from and to the core domain.
	input wire logic req_tgl,
	output logic [15:0] word,
	output logic word_tgl,
	output logic done_tgl,
	output logic err,
	// Open-drain pins; enable high pulls the line low.
	input wire logic scl_i,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_oe
);
	// Bus operation in progress.
	typedef enum {L_IDLE, L_START, L_WB, L_RB, L_STOP} bcl_op_t;
	// Whole state of the link end.
	typedef struct packed {
		logic rq1, rq2, rq3;
		logic sd1, sd2;
		bcl_op_t op;
		logic [1:0] q;
		logic [7:0] div;
		logic [3:0] bitn;
		logic [5:0] nbyte;
		logic [1:0] seq;
		logic [7:0] sh;
		logic [7:0] hi;
		logic [15:0] word;
		logic wt, dt, err, scl_oe, sda_oe;
	} bcl_link_t;
	bcl_link_t s, n;
	logic tick;
	logic last;

	// Bit sequencing: each bit is four quarters of SCL low/high.
	always_comb begin
		n = s;
		n.rq1 = req_tgl;
		n.rq2 = s.rq1;
		n.rq3 = s.rq2;
		n.sd1 = sda_i;
		n.sd2 = s.sd1;
		tick = s.div == 8'(QUARTER_LEN - 1);
		last = s.nbyte == 6'(bcl_pkg::ICE_BYTES - 1);
		n.div = (tick || s.op == L_IDLE) ? '0 : s.div + 8'd1;
		if (s.op == L_IDLE) begin
			// A new request toggle starts a full image read.
			if (s.rq2 ^ s.rq3) begin
				n.op = L_START;
				n.q = '0;
				n.seq = '0;
				n.nbyte = '0;
				n.err = 1'b0;
			end
		end else if (tick) begin
			n.q = s.q + 2'd1;
			case (s.op)
				L_START: begin
					// Start and repeated start share one pattern.
					case (s.q)
						2'd0: n.sda_oe = 1'b0;
						2'd1: n.scl_oe = 1'b0;
						2'd2: n.sda_oe = 1'b1;
						default: begin
							n.scl_oe = 1'b1;
							n.op = L_WB;
							n.bitn = '0;
							// Dummy write sets address 0, then read.
							n.sh = (s.seq == '0) ? bcl_pkg::ICE_WR_ADDR :
								bcl_pkg::ICE_RD_ADDR;
						end
					endcase
				end
				L_WB, L_RB: begin
					case (s.q)
						2'd0: begin
							// Data, or our acknowledge while reading.
							if (s.bitn < 4'd8)
								n.sda_oe = (s.op == L_WB) ? ~s.sh[7] : 1'b0;
							else
								n.sda_oe = (s.op == L_RB) && !last;
						end
						2'd1: n.scl_oe = 1'b0;
						2'd2: begin
							// Shifting in the line serves both directions.
							if (s.bitn < 4'd8)
								n.sh = {s.sh[6:0], s.sd2};
							else if (s.op == L_WB && s.sd2)
								n.err = 1'b1;
						end
						default: begin
							n.scl_oe = 1'b1;
							n.bitn = s.bitn + 4'd1;
							if (s.bitn == 4'd8) begin
								n.bitn = '0;
								n.sda_oe = 1'b0;
								if (s.op == L_RB) begin
									// First byte is the high half.
									if (!s.nbyte[0]) begin
										n.hi = s.sh;
									end else begin
										n.word = {s.hi, s.sh};
										n.wt = ~s.wt;
									end
									n.nbyte = s.nbyte + 6'd1;
									if (last)
										n.op = L_STOP;
								end else if (s.err) begin
									// Missing or silent EEPROM ends early.
									n.op = L_STOP;
								end else begin
									n.seq = s.seq + 2'd1;
									// Only address bytes are ever sent.
									if (s.seq == 2'd0)
										n.sh = bcl_pkg::ICE_START;
									else if (s.seq == 2'd1)
										n.op = L_START;
									else
										n.op = L_RB;
								end
							end
						end
					endcase
				end
				L_STOP: begin
					case (s.q)
						2'd0: n.sda_oe = 1'b1;
						2'd1: n.scl_oe = 1'b0;
						2'd2: n.sda_oe = 1'b0;
						default: begin
							n.op = L_IDLE;
							n.dt = ~s.dt;
						end
					endcase
				end
				default: n.op = L_IDLE;
			endcase
		end
	end

	// State register of the link end.
	always_ff @(posedge i2c_clk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end

	assign word = s.word;
	assign word_tgl = s.wt;
	assign done_tgl = s.dt;
	assign err = s.err;
	assign scl_oe = s.scl_oe;
	assign sda_oe = s.sda_oe;

	a_ack_release: assert property (@(posedge i2c_clk) disable iff (rst)
		(s.op == L_RB && s.bitn < 4'd8 && s.q == 2'd1) |-> !s.sda_oe)
		else $error("link drives data while reading");
endmodule

////////////////////////////////////////////////////////////////////////////
// Configuration loader in the always-on core domain.
module bcl_loader #(
	parameter logic [15:0] UNLOCK_KEY = 16'h1234, // Arbitrary value.
	// Link cycles per quarter bit; sets the serial bus rate.
	parameter int QUARTER_LEN = bcl_pkg::QUARTER_CYC
) (
	// Core clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Serial link clock.
	input wire logic i2c_clk,
	// Power sequencer handshake.
	input wire bcl_pkg::bcl_pwr_t pwr_state,
	input wire logic on_req,
	output logic start_ok,
	output logic start_fail,
	output logic prog_state,
	// Control interface.
	input wire bcl_pkg::bcl_host_req_t host_req,
	output logic [15:0] host_rdata,
	// One-time memory port.
	output bcl_pkg::bcl_otp_req_t otp_req,
	input wire logic [15:0] otp_rdata,
	// Secondary serial pins, open drain.
	input wire logic secondary_serial_clock_pin_i,
	output logic secondary_serial_clock_pin_o,
	output logic secondary_serial_clock_pin_oe,
	input wire logic secondary_serial_data_pin_i,
	output logic secondary_serial_data_pin_o,
	output logic secondary_serial_data_pin_oe
);
	// Loader sequence.
	typedef enum {S_IDLE, S_OTP, S_ICE, S_CHECK, S_PROG, S_OTPWR}
		bcl_state_t;
	// Whole state of the core end.
	typedef struct packed {
		bcl_state_t st;
		logic [bcl_pkg::WIN_WORDS-1:0][15:0] win;
		logic reload, reload_now, unlocked, dev, fail, ice_err, prog;
		logic [5:0] cnt;
		logic rd_pend;
		logic [4:0] rd_idx;
		logic [bcl_pkg::GPIO_COUNT-1:0] otp_pol;
		logic start_ok, start_fail, req_tgl;
		logic wd1, wd2, wd3, dn1, dn2, dn3, sc1, sc2;
		logic [15:0] rdata;
		bcl_pkg::bcl_otp_req_t otp;
	} bcl_core_t;
	bcl_core_t s, n;
	logic [15:0] link_word;
	logic link_wt, link_dt, link_err;

	// Link end; word and error are stable long before their toggles
	// are seen here, so they are read without their own synchroniser.
	bcl_link #(.QUARTER_LEN(QUARTER_LEN)) u_link (
		.i2c_clk(i2c_clk),
		.rst(rst),
		.req_tgl(s.req_tgl),
		.word(link_word),
		.word_tgl(link_wt),
		.done_tgl(link_dt),
		.err(link_err),
		.scl_i(secondary_serial_clock_pin_i),
		.scl_oe(secondary_serial_clock_pin_oe),
		.sda_i(secondary_serial_data_pin_i),
		.sda_oe(secondary_serial_data_pin_oe)
	);

	////////////////////////////////////////////////////////////////////////
	// Register decode, window access and load sequencing.
	always_comb begin
		logic [15:0] woff;
		logic win_hit, ok;
		int idx;
		logic [15:0] w;
		woff = host_req.addr - bcl_pkg::ADDR_WIN;
		win_hit = host_req.addr >= bcl_pkg::ADDR_WIN &&
			woff < 16'(bcl_pkg::WIN_WORDS);
		ok = 1'b0;
		idx = 0;
		w = '0;
		n = s;
		n.start_ok = 1'b0;
		n.start_fail = 1'b0;
		n.otp.rd = 1'b0;
		n.otp.wr = 1'b0;
		n.wd1 = link_wt;
		n.wd2 = s.wd1;
		n.wd3 = s.wd2;
		n.dn1 = link_dt;
		n.dn2 = s.dn1;
		n.dn3 = s.dn2;
		n.sc1 = secondary_serial_clock_pin_i;
		n.sc2 = s.sc1;
		// Reads; the memories themselves have no address here.
		if (host_req.rd) begin
			n.rdata = '0;
			if (host_req.addr == bcl_pkg::ADDR_RELOAD)
				n.rdata[bcl_pkg::RELOAD_BIT] = s.reload;
			else if (host_req.addr == bcl_pkg::ADDR_STATUS) begin
				n.rdata[bcl_pkg::ST_BUSY] = s.st != S_IDLE && s.st != S_PROG;
				n.rdata[bcl_pkg::ST_DEV] = s.dev;
				n.rdata[bcl_pkg::ST_FAIL] = s.fail;
				n.rdata[bcl_pkg::ST_ICE_ERR] = s.ice_err;
				n.rdata[bcl_pkg::ST_PROG] = s.prog;
			end else if (win_hit)
				n.rdata = s.win[woff[5:0]];
		end
		// Writes.
		if (host_req.wr) begin
			if (host_req.addr == bcl_pkg::ADDR_SECURITY) begin
				// Any other value locks again.
				n.unlocked = host_req.data == UNLOCK_KEY;
			end else if (host_req.addr == bcl_pkg::ADDR_RELOAD) begin
				if (s.unlocked)
					n.reload = host_req.data[bcl_pkg::RELOAD_BIT];
			end else if (host_req.addr == bcl_pkg::ADDR_MEMCTL) begin
				if (host_req.data[bcl_pkg::PROG_REQ_BIT] && !on_req &&
					s.st == S_IDLE && pwr_state == bcl_pkg::PWR_OFF) begin
					n.st = S_PROG;
					n.prog = 1'b1;
				end else if (host_req.data[bcl_pkg::OTP_WRITE_BIT] &&
					s.st == S_PROG) begin
					n.st = S_OTPWR;
					n.cnt = '0;
				end
			end else if (win_hit && woff >= 16'(bcl_pkg::FACT_WORDS) &&
				(s.st == S_IDLE || s.st == S_PROG)) begin
				// Pages 0 and 1 are never written by the host.
				n.win[woff[5:0]] = host_req.data;
			end
		end
		case (s.st)
			S_IDLE: begin
				if (on_req) begin
					n.st = S_OTP;
					n.dev = s.sc2;
					n.reload_now = s.reload;
					n.ice_err = 1'b0;
					n.cnt = '0;
				end
			end
			S_OTP: begin
				// Data returns one cycle after the read strobe.
				n.rd_pend = s.otp.rd;
				n.rd_idx = s.otp.addr;
				if (s.rd_pend) begin
					idx = int'(s.rd_idx);
					// Factory pages always; bootstrap only if chosen.
					if (idx < bcl_pkg::FACT_WORDS ||
						(!s.dev && s.reload_now))
						n.win[s.rd_idx] = otp_rdata;
					// Keep OTP polarity bits for the development check.
					if (idx >= bcl_pkg::GPIO_WORD &&
						idx < bcl_pkg::GPIO_WORD + bcl_pkg::GPIO_COUNT)
						n.otp_pol[idx - bcl_pkg::GPIO_WORD] =
							otp_rdata[bcl_pkg::POL_BIT];
				end
				if (s.cnt < 6'(bcl_pkg::OTP_WORDS)) begin
					n.otp.rd = 1'b1;
					n.otp.addr = s.cnt[4:0];
					n.cnt = s.cnt + 6'd1;
				end else if (!s.otp.rd && !s.rd_pend) begin
					if (s.dev && s.reload_now) begin
						n.req_tgl = ~s.req_tgl;
						n.cnt = '0;
						n.st = S_ICE;
					end else
						n.st = S_CHECK;
				end
			end
			S_ICE: begin
				if ((s.wd2 ^ s.wd3) && s.cnt < 6'(bcl_pkg::ICE_WORDS)) begin
					idx = bcl_pkg::ICE_BASE + int'(s.cnt);
					w = link_word;
					// Active-high power request needs OTP consent.
					if (idx >= bcl_pkg::GPIO_WORD &&
						idx < bcl_pkg::GPIO_WORD + bcl_pkg::GPIO_COUNT &&
						w[7:0] == bcl_pkg::FN_PWR_REQ &&
						!s.otp_pol[idx - bcl_pkg::GPIO_WORD])
						w[bcl_pkg::POL_BIT] = 1'b0;
					n.win[idx] = w;
					n.cnt = s.cnt + 6'd1;
				end
				if (s.dn2 ^ s.dn3) begin
					n.ice_err = link_err;
					n.st = S_CHECK;
				end
			end
			S_CHECK: begin
				ok = s.win[bcl_pkg::CUST_ID_WORD] != '0 &&
					(!s.dev || (!s.ice_err &&
					s.win[bcl_pkg::VALID_WORD] == bcl_pkg::VALID_CODE));
				n.start_ok = ok;
				n.start_fail = !ok;
				n.fail = !ok;
				n.st = S_IDLE;
			end
			S_OTPWR: begin
				// Burn pages 2 and 3 only.
				if (s.cnt < 6'(bcl_pkg::FACT_WORDS)) begin
					n.otp.wr = 1'b1;
					n.otp.addr = 5'(bcl_pkg::FACT_WORDS) + s.cnt[4:0];
					n.otp.data = s.win[bcl_pkg::FACT_WORDS + int'(s.cnt)];
					n.cnt = s.cnt + 6'd1;
				end else
					n.st = S_PROG;
			end
			default: ;
		endcase
	end

	// State register; reload defaults to enabled.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.reload <= bcl_pkg::RESET_RELOAD[bcl_pkg::RELOAD_BIT];
		end else
			s <= n;
	end

	assign start_ok = s.start_ok;
	assign start_fail = s.start_fail;
	assign prog_state = s.prog;
	assign host_rdata = s.rdata;
	assign otp_req = s.otp;
	// Open-drain lines only ever pull low.
	assign secondary_serial_clock_pin_o = 1'b0;
	assign secondary_serial_data_pin_o = 1'b0;

	////////////////////////////////////////////////////////////////////////
	a_page0_fixed: assert property (@(posedge clk) disable iff (rst)
		(host_req.wr && host_req.addr == bcl_pkg::ADDR_WIN && s.st == S_IDLE)
		|=> s.win[0] == $past(s.win[0]))
		else $error("page 0 changed by host write");
	a_page1_fixed: assert property (@(posedge clk) disable iff (rst)
		(host_req.wr && s.st == S_PROG &&
		host_req.addr == bcl_pkg::ADDR_WIN + 16'(bcl_pkg::PAGE_WORDS))
		|=> s.win[bcl_pkg::PAGE_WORDS] == $past(s.win[bcl_pkg::PAGE_WORDS]))
		else $error("page 1 changed by host write");
	a_ok_needs_id: assert property (@(posedge clk) disable iff (rst)
		s.start_ok |-> s.win[bcl_pkg::CUST_ID_WORD] != '0)
		else $error("start with zero customer identifier");
	a_dev_valid: assert property (@(posedge clk) disable iff (rst)
		(s.start_ok && s.dev) |->
		s.win[bcl_pkg::VALID_WORD] == bcl_pkg::VALID_CODE && !s.ice_err)
		else $error("start with invalid EEPROM image");
	a_prog_from_off: assert property (@(posedge clk) disable iff (rst)
		$rose(s.prog) |-> $past(pwr_state) == bcl_pkg::PWR_OFF)
		else $error("programming state entered outside OFF");
	a_otp_wr_prog: assert property (@(posedge clk) disable iff (rst)
		s.otp.wr |-> s.prog && s.otp.addr >= 5'(bcl_pkg::FACT_WORDS))
		else $error("OTP write outside programming or to factory page");
	a_reload_key: assert property (@(posedge clk) disable iff (rst)
		$changed(s.reload) |-> $past(s.unlocked))
		else $error("reload bit changed while locked");
	a_wait_check: assert property (@(posedge clk) disable iff (rst)
		(s.start_ok || s.start_fail) |-> $past(s.st) == S_CHECK)
		else $error("start verdict before loads finished");
endmodule

/* File: design/bcl_pkg.sv */
package bcl_pkg;
	// Window geometry in 16-bit words.
	localparam int PAGE_WORDS = 8;
	localparam int WIN_WORDS = 40;
	localparam int FACT_WORDS = 16;
	localparam int OTP_WORDS = 32;
	localparam int ICE_BASE = 16;
	localparam int ICE_WORDS = 24;
	localparam int ICE_BYTES = 48;
	// Register addresses on the control interface.
	localparam logic [15:0] ADDR_RELOAD = 16'h4006;
	localparam logic [15:0] ADDR_SECURITY = 16'h4008;
	localparam logic [15:0] ADDR_MEMCTL = 16'h400A;
	localparam logic [15:0] ADDR_STATUS = 16'h400C;
	localparam logic [15:0] ADDR_WIN = 16'h5000;
	// Field positions.
	localparam int RELOAD_BIT = 15;
	localparam int PROG_REQ_BIT = 15;
	localparam int OTP_WRITE_BIT = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_DEV = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_ICE_ERR = 3;
	localparam int ST_PROG = 4;
	localparam int POL_BIT = 8;
	// Validity words and GPIO configuration words inside the window.
	localparam int CUST_ID_WORD = 16;
	localparam int VALID_WORD = 32;
	localparam int GPIO_WORD = 24;
	localparam int GPIO_COUNT = 6;
	localparam logic [15:0] VALID_CODE = 16'hA596;
	localparam logic [7:0] FN_PWR_REQ = 8'h02;
	localparam logic [15:0] RESET_RELOAD = 16'h8000;
	// Serial EEPROM bus bytes.
	localparam logic [7:0] ICE_RD_ADDR = 8'hA1;
	localparam logic [7:0] ICE_WR_ADDR = 8'hA0;
	localparam logic [7:0] ICE_START = 8'h00;
	// Serial bus timing: one quarter of a bit period.
	localparam int QUARTER_NS = 2500;
	localparam int LINK_PERIOD_NS = 15;
	localparam int QUARTER_CYC =
		(QUARTER_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
	// Power state reported by the main sequencer.
	typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_SLEEP} bcl_pwr_t;
	// Control interface request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] data;
	} bcl_host_req_t;
	// One-time memory request; read data returns one cycle after rd.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic [15:0] data;
	} bcl_otp_req_t;
endpackage

/* File: test/bcl_eeprom_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Behavioural serial EEPROM that answers reads and logs received bytes.
module bcl_eeprom_model (
	// Wire levels on the bus.
	input wire logic scl,
	input wire logic sda,
	// Low models an empty socket that acknowledges nothing.
	input wire logic present,
	// High pulls the data line low.
	output logic sda_oe,
	// Received bytes, newest in the low byte.
	output logic [31:0] rx_log,
	// Set when a data byte follows the pointer in a write.
	output logic wr_seen
);
	logic [7:0] shreg; // Receive shift register.
	logic [3:0] bitn; // Clock count within a byte.
	logic [5:0] ptr; // Read pointer.
	logic rd_mode; // High while sending data to the loader.
	logic [7:0] dbyte; // Byte at the read pointer.
	logic [7:0] mem [0:63]; // Image of pages 2 to 4 in bytes.
	int nbytes; // Bytes since the last START.
	assign dbyte = mem[ptr];
	initial begin
		sda_oe = 1'b0;
		rx_log = 32'h0000_0000;
		wr_seen = 1'b0;
		bitn = 4'h0;
		ptr = 6'h00;
		rd_mode = 1'b0;
		nbytes = 0;
		for (int i = 0; i < 64; i++) begin
			mem[i] = {2'b10, 6'(i)};
		end
		// Word 24 asks for power request, active low.
		mem[17] = 8'h02;
		// Words 25 and 26 ask for active high, which needs OTP consent.
		mem[18] = 8'h93;
		mem[19] = 8'h02;
		mem[20] = 8'h95;
		mem[21] = 8'h02;
		// Validity word at the start of page 4.
		mem[32] = 8'hA5;
		mem[33] = 8'h96;
	end
	// START or repeated START restarts byte framing.
	always @(negedge sda) begin
		if (scl) begin
			bitn = 4'h0;
			nbytes = 0;
			rd_mode = 1'b0;
		end
	end
	// Sample on the rising clock; a high ninth bit ends a read.
	always @(posedge scl) begin
		if (bitn < 4'h8 && !rd_mode) begin
			shreg = {shreg[6:0], sda};
		end
		if (bitn == 4'h8 && rd_mode && sda) begin
			rd_mode = 1'b0;
		end
		bitn = bitn + 4'h1;
	end
	// Drive only while the clock is low, so no false START or STOP.
	always @(negedge scl) begin
		if (bitn == 4'h8 && !rd_mode) begin
			rx_log = {rx_log[23:0], shreg};
			if (nbytes == 0) begin
				sda_oe = present && shreg[7:1] == 7'h50;
				rd_mode = sda_oe && shreg[0];
			end else begin
				sda_oe = present;
				wr_seen = wr_seen || nbytes > 1;
				ptr = (nbytes == 1) ? shreg[5:0] : ptr;
			end
			nbytes = nbytes + 1;
		end else if (bitn == 4'h8) begin
			// Leave the acknowledge slot to the loader.
			sda_oe = 1'b0;
			ptr = ptr + 6'h01;
		end else if (bitn == 4'h9) begin
			bitn = 4'h0;
			sda_oe = rd_mode && !dbyte[7];
		end else begin
			sda_oe = rd_mode && !dbyte[4'h7 - bitn];
		end
	end
endmodule

/* File: test/bcl_loader_tb.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the configuration loader.
module bcl_loader_tb;
	localparam logic [15:0] KEY = 16'h1234; // Arbitrary unlock value.
	logic clk; // Core clock.
	logic i2c_clk; // Link clock.
	logic rst; // Shared reset.
	bcl_pkg::bcl_pwr_t pwr_state; // Sequencer state.
	logic on_req;
	logic start_ok;
	logic start_fail;
	logic prog_state;
	bcl_pkg::bcl_host_req_t host_req;
	logic [15:0] host_rdata;
	bcl_pkg::bcl_otp_req_t otp_req;
	logic [15:0] otp_rdata;
	logic [15:0] otp_mem [0:31]; // One-time memory contents.
	int otp_wr_cnt; // Program pulses seen.
	logic dev_pull; // Pull-up on the clock pin selects development.
	logic present; // EEPROM fitted.
	logic scl_oe;
	logic sda_oe;
	logic mdl_sda_oe;
	logic scl_w;
	logic sda_w;
	logic [31:0] rx_log;
	logic wr_seen;
	logic [15:0] win_exp [0:39]; // Expected window.
	int miscompares;
	int comparisons;
	// Open-drain wires; a released line goes to its resistor level.
	assign scl_w = dev_pull && !scl_oe;
	assign sda_w = !sda_oe && !mdl_sda_oe;
	// A short serial bit keeps a whole image read brief.
	bcl_loader #(.UNLOCK_KEY(KEY), .QUARTER_LEN(4)) i_dut (
		.clk(clk), .rst(rst), .i2c_clk(i2c_clk), .pwr_state(pwr_state),
		.on_req(on_req), .start_ok(start_ok), .start_fail(start_fail),
		.prog_state(prog_state), .host_req(host_req),
		.host_rdata(host_rdata), .otp_req(otp_req), .otp_rdata(otp_rdata),
		.secondary_serial_clock_pin_i(scl_w),
		.secondary_serial_clock_pin_o(),
		.secondary_serial_clock_pin_oe(scl_oe),
		.secondary_serial_data_pin_i(sda_w),
		.secondary_serial_data_pin_o(),
		.secondary_serial_data_pin_oe(sda_oe)
	);
	bcl_eeprom_model i_eeprom (
		.scl(scl_w), .sda(sda_w), .present(present),
		.sda_oe(mdl_sda_oe), .rx_log(rx_log), .wr_seen(wr_seen)
	);
	// Core clock at 25 ns.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Link clock at 15 ns, offset so the phases are unrelated.
	initial begin
		i2c_clk = 1'b0;
		#3.3;
		forever #7.5 i2c_clk = ~i2c_clk;
	end
	// Memory model: data one cycle after a read; a changing value
	// otherwise so a stale sample cannot pass.
	always @(posedge clk) begin
		if (otp_req.rd) begin
			otp_rdata <= otp_mem[otp_req.addr];
		end else begin
			otp_rdata <= ~otp_rdata;
		end
		if (otp_req.wr) begin
			check(otp_req.addr, 16 + otp_wr_cnt, "otp addr");
			check(otp_req.data, win_exp[16 + otp_wr_cnt], "otp data");
			otp_wr_cnt <= otp_wr_cnt + 1;
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Every task starts and ends 2 ns after a rising edge.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic do_reset();
		rst = 1'b1;
		tick(16);
		rst = 1'b0;
	endtask
	task automatic host_wr(input logic [15:0] a, input logic [15:0] d);
		host_req = '{1'b1, 1'b0, a, d};
		tick(1);
		host_req.wr = 1'b0;
		tick(1); // Idle edge before the next request.
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] e,
		input string what);
		host_req = '{1'b0, 1'b1, a, 16'h0000};
		tick(1);
		host_req.rd = 1'b0;
		tick(1);
		check(host_rdata, e, what);
	endtask
	task automatic chk_win(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			rd_chk(bcl_pkg::ADDR_WIN + 16'(i), win_exp[i], "window");
		end
	endtask
	task automatic set_reload(input logic [15:0] v);
		host_wr(bcl_pkg::ADDR_SECURITY, KEY);
		host_wr(bcl_pkg::ADDR_RELOAD, v);
	endtask
	task automatic load_exp();
		for (int i = 0; i < 32; i++) begin
			win_exp[i] = otp_mem[i];
		end
	endtask
	// Schedules a start and waits, bounded, for the verdict pulse.
	task automatic boot(input logic exp_ok, input int limit);
		int n;
		n = 0;
		on_req = 1'b1;
		tick(1);
		on_req = 1'b0;
		while (start_ok !== 1'b1 && start_fail !== 1'b1 && n < limit) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= limit) begin
			miscompares++;
			$display("unexpected at %0t: no start verdict", $time);
			tally_and_finish();
		end
		#1;
		check(start_ok, exp_ok, "verdict");
		check(start_fail, !exp_ok, "fail pulse");
	endtask
	task automatic t_reset();
		rd_chk(bcl_pkg::ADDR_RELOAD, 16'h8000, "reload"); // Default.
		chk_win(0, 39); // Cleared window.
		rd_chk(16'h4100, 16'h0000, "unmapped"); // Reads zero.
		$display("test reset done");
	endtask
	task automatic t_lock();
		host_wr(bcl_pkg::ADDR_RELOAD, 16'h0000);
		rd_chk(bcl_pkg::ADDR_RELOAD, 16'h8000, "locked"); // Kept.
		host_wr(bcl_pkg::ADDR_SECURITY, 16'h4321);
		host_wr(bcl_pkg::ADDR_RELOAD, 16'h0000);
		rd_chk(bcl_pkg::ADDR_RELOAD, 16'h8000, "bad key"); // Kept.
		set_reload(16'h0000);
		rd_chk(bcl_pkg::ADDR_RELOAD, 16'h0000, "unlocked"); // Taken.
		set_reload(16'h8000);
		$display("test lock done");
	endtask
	task automatic t_otp_boot();
		boot(1'b1, 200); // Waits for loads.
		load_exp();
		chk_win(0, 39); // Pages 0 to 3 only.
		rd_chk(bcl_pkg::ADDR_STATUS, 16'h0000, "status"); // Normal.
		pwr_state = bcl_pkg::PWR_ON;
		host_wr(bcl_pkg::ADDR_WIN, 16'hFFFF);
		host_wr(bcl_pkg::ADDR_WIN + 16'h0008, 16'hFFFF);
		host_wr(bcl_pkg::ADDR_WIN + 16'h0014, 16'h5A5A);
		win_exp[20] = 16'h5A5A;
		chk_win(0, 20); // Fixed pages stay.
		$display("test otp boot done");
	endtask
	task automatic t_no_reload();
		set_reload(16'h0000);
		otp_mem[0] = 16'hBEEF;
		otp_mem[20] = 16'h7777;
		win_exp[0] = 16'hBEEF;
		boot(1'b1, 200); // Starts from window.
		chk_win(0, 39); // Only pages 0, 1 refetched.
		host_wr(bcl_pkg::ADDR_WIN + 16'h0010, 16'h0000);
		boot(1'b0, 200); // Check still made.
		rd_chk(bcl_pkg::ADDR_STATUS, 16'h0004, "fail"); // Off.
		set_reload(16'h8000);
		otp_mem[16] = 16'h0000;
		boot(1'b0, 200); // Zero identifier.
		otp_mem[16] = 16'h1110;
		boot(1'b1, 200); // Reloaded and valid.
		load_exp();
		chk_win(0, 39); // Bootstrap refetched.
		$display("test reload done");
	endtask
	task automatic t_prog();
		host_wr(bcl_pkg::ADDR_MEMCTL, 16'h8000);
		tick(3);
		check(prog_state, 1'b0, "prog in on"); // Refused.
		pwr_state = bcl_pkg::PWR_OFF;
		host_wr(bcl_pkg::ADDR_MEMCTL, 16'h0002);
		tick(40);
		check(otp_wr_cnt, 0, "early write"); // Refused.
		host_wr(bcl_pkg::ADDR_MEMCTL, 16'h8000);
		tick(1);
		check(prog_state, 1'b1, "prog entry"); // From off.
		host_wr(bcl_pkg::ADDR_WIN + 16'h0008, 16'hFFFF);
		rd_chk(bcl_pkg::ADDR_WIN + 16'h0008, win_exp[8], "page 1");
		host_wr(bcl_pkg::ADDR_WIN + 16'h0011, 16'h3C3C);
		win_exp[17] = 16'h3C3C;
		host_wr(bcl_pkg::ADDR_MEMCTL, 16'h0002);
		for (int n = 0; n < 400 && otp_wr_cnt < 16; n++) begin
			tick(1);
		end
		tick(10);
		check(otp_wr_cnt, 16, "write count"); // Pages 2, 3.
		$display("test prog done");
	endtask
	task automatic t_dev();
		dev_pull = 1'b1;
		present = 1'b0;
		do_reset();
		tick(3);
		boot(1'b0, 20000); // Absent memory.
		rd_chk(bcl_pkg::ADDR_STATUS, 16'h000E, "dev"); // Flags.
		check(rx_log[7:0], bcl_pkg::ICE_WR_ADDR, "addr"); // First.
		present = 1'b1;
		otp_mem[25] = 16'h1019; // OTP withholds active high here.
		boot(1'b1, 20000); // Valid image read.
		check(rx_log[23:0], {bcl_pkg::ICE_WR_ADDR, bcl_pkg::ICE_START,
			bcl_pkg::ICE_RD_ADDR}, "read preamble"); // Address.
		check(wr_seen, 1'b0, "write seen"); // Read only.
		rd_chk(bcl_pkg::ADDR_STATUS, 16'h0002, "dev ok");
		load_exp();
		for (int i = 0; i < 24; i++) begin
			win_exp[16 + i] = {i_eeprom.mem[2 * i],
				i_eeprom.mem[2 * i + 1]}; // Big-endian.
		end
		win_exp[25][bcl_pkg::POL_BIT] = 1'b0; // No OTP consent.
		chk_win(0, 39); // Pages 2 to 4 from image.
		on_req = 1'b1;
		tick(1);
		on_req = 1'b0;
		tick(200);
		rst = 1'b1;
		tick(2);
		check({scl_oe, sda_oe, prog_state, start_ok}, 4'h0, "mid reset");
		rst = 1'b0;
		tick(2);
		rd_chk(bcl_pkg::ADDR_RELOAD, 16'h8000, "reload"); // Default.
		$display("test dev done");
	endtask
	// Main sequence.
	initial begin
		rst = 1'b1;
		on_req = 1'b0;
		host_req = '0;
		pwr_state = bcl_pkg::PWR_OFF;
		dev_pull = 1'b0;
		present = 1'b1;
		otp_rdata = 16'h0000;
		otp_wr_cnt = 0;
		miscompares = 0;
		comparisons = 0;
		for (int i = 0; i < 40; i++) begin
			win_exp[i] = 16'h0000;
		end
		for (int i = 0; i < 32; i++) begin
			otp_mem[i] = 16'h1100 + 16'(i);
		end
		do_reset();
		t_reset();
		t_lock();
		t_otp_boot();
		t_no_reload();
		t_prog();
		t_dev();
		tally_and_finish();
	end
endmodule
